// ---- hdl/serial_frame_send_receive.sv ----
// serial frame send and receive engine with AXI4-Lite register slave
`timescale 1ns/10ps
module serial_frame_send_receive import serial_frame_pkg::*; #(
	parameter int MS_CYCLES_P = MS_CYCLES
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [7:0] tx_data_one,
	output logic tx_valid_one,
	input wire logic tx_ready_one,
	input wire logic [7:0] rx_data_one,
	input wire logic rx_valid_one,
	output logic [7:0] tx_data_two,
	output logic tx_valid_two,
	input wire logic tx_ready_two,
	input wire logic [7:0] rx_data_two,
	input wire logic rx_valid_two,
	input wire logic claim_one_other,
	input wire logic claim_two_other,
	output logic port_one_claimed,
	output logic port_two_claimed,
	output logic error_flag
);
	// bus side state
	logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d, awready_q, awready_d, wready_q, wready_d;
	logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [11:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic [1:0] ctrl_q, ctrl_d;
	logic [15:0] port_select_q, port_select_d, tx_length_q, tx_length_d;
	logic [15:0] rx_mode_word_q, rx_mode_word_d, param_q, param_d, tperiod_q, tperiod_d;
	logic [15:0] txcap_q, txcap_d, rxcap_q, rxcap_d;
	logic do_wr, rd_take, clr_done, clr_tout, clr_err, txbuf_we;
	// engine state
	engine_state_e st_q, st_d;
	logic done_q, done_d, timeout_q, timeout_d, err_q, err_d, abort_q, abort_d;
	logic sel_two_q, sel_two_d, hi_q, hi_d, rx_hi_phase_q, rx_hi_phase_d;
	logic started_q, started_d, have_prev_q, have_prev_d;
	logic txv_one_q, txv_one_d, txv_two_q, txv_two_d, claim_one_q, claim_two_q;
	logic [15:0] errcode_q, errcode_d, gap_q, gap_d, tmo_q, tmo_d;
	logic [9:0] tx_idx_q, tx_idx_d, rx_cnt_q, rx_cnt_d;
	logic [7:0] tx_byte_q, tx_byte_d, rx_hi_q, rx_hi_d, prev_q, prev_d;
	// engine helpers
	logic en, eight, bad, port_busy, rx_fire, tx_fire, tick, restart, ends, mode_gap;
	logic rx_we, store_ok;
	logic [7:0] rx_byte;
	logic [15:0] tx_word, rx_rd, rx_wword, gap_set;

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	assign en = ctrl_q[CTRL_EN];
	assign eight = ctrl_q[CTRL_8BIT];

	// AXI4-Lite write and read channels
	always_comb begin
		aw_hold_d = aw_hold_q;
		awaddr_d = awaddr_q;
		w_hold_d = w_hold_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		ctrl_d = ctrl_q;
		port_select_d = port_select_q;
		tx_length_d = tx_length_q;
		rx_mode_word_d = rx_mode_word_q;
		param_d = param_q;
		tperiod_d = tperiod_q;
		txcap_d = txcap_q;
		rxcap_d = rxcap_q;
		clr_done = 1'b0;
		clr_tout = 1'b0;
		clr_err = 1'b0;
		txbuf_we = 1'b0;
		if (s_axi_awvalid && awready_q) begin
			aw_hold_d = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_q) begin
			w_hold_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		do_wr = aw_hold_q && w_hold_q && !bvalid_q;
		if (do_wr) begin
			aw_hold_d = 1'b0;
			w_hold_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = RESP_OKAY;
			if (awaddr_q[11:8] == WIN_TXBUF) begin
				txbuf_we = 1'b1;
			end else begin
				case ({awaddr_q[11:2], 2'b00})
					OFS_CTRL: ctrl_d = 2'(merge({14'h0000, ctrl_q}, wdata_q, wstrb_q));
					OFS_PORT: port_select_d = merge(port_select_q, wdata_q, wstrb_q);
					OFS_TXLEN: tx_length_d = merge(tx_length_q, wdata_q, wstrb_q);
					OFS_MODE: rx_mode_word_d = merge(rx_mode_word_q, wdata_q, wstrb_q);
					OFS_PARAM: param_d = merge(param_q, wdata_q, wstrb_q);
					OFS_TOUT: tperiod_d = merge(tperiod_q, wdata_q, wstrb_q);
					OFS_TXCAP: txcap_d = merge(txcap_q, wdata_q, wstrb_q);
					OFS_RXCAP: rxcap_d = merge(rxcap_q, wdata_q, wstrb_q);
					OFS_STAT: begin
						clr_done = wstrb_q[0] && wdata_q[ST_DONE];
						clr_tout = wstrb_q[0] && wdata_q[ST_TOUT];
						clr_err = wstrb_q[0] && wdata_q[ST_ERR];
					end
					default: bresp_d = RESP_SLVERR;
				endcase
			end
		end
		awready_d = !aw_hold_d;
		wready_d = !w_hold_d;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
		rd_take = s_axi_arvalid && arready_q;
		if (rd_take) begin
			rvalid_d = 1'b1;
			rresp_d = RESP_OKAY;
			rdata_d = 32'h0000_0000;
			if (s_axi_araddr[11:8] == WIN_RXBUF) begin
				rdata_d = {16'h0000, rx_rd};
			end else begin
				case ({s_axi_araddr[11:2], 2'b00})
					OFS_CTRL: rdata_d = {30'h0000_0000, ctrl_q};
					OFS_PORT: rdata_d = {16'h0000, port_select_q};
					OFS_TXLEN: rdata_d = {16'h0000, tx_length_q};
					OFS_MODE: rdata_d = {16'h0000, rx_mode_word_q};
					OFS_PARAM: rdata_d = {16'h0000, param_q};
					OFS_TOUT: rdata_d = {16'h0000, tperiod_q};
					OFS_TXCAP: rdata_d = {16'h0000, txcap_q};
					OFS_RXCAP: rdata_d = {16'h0000, rxcap_q};
					OFS_STAT: rdata_d = {6'h00, rx_cnt_q, 11'h000, st_q != st_idle,
						st_q == st_recv && started_q, err_q, timeout_q, done_q};
					OFS_ERR: rdata_d = {16'h0000, errcode_q};
					default: rresp_d = RESP_SLVERR;
				endcase
			end
		end
		arready_d = !rvalid_d && !rd_take;
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awaddr_q <= 12'h000;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= RESP_OKAY;
			ctrl_q <= 2'b00;
			port_select_q <= REG_RST;
			tx_length_q <= REG_RST;
			rx_mode_word_q <= REG_RST;
			param_q <= REG_RST;
			tperiod_q <= REG_RST;
			txcap_q <= REG_RST;
			rxcap_q <= REG_RST;
		end else if (ce) begin
			aw_hold_q <= aw_hold_d;
			w_hold_q <= w_hold_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
			ctrl_q <= ctrl_d;
			port_select_q <= port_select_d;
			tx_length_q <= tx_length_d;
			rx_mode_word_q <= rx_mode_word_d;
			param_q <= param_d;
			tperiod_q <= tperiod_d;
			txcap_q <= txcap_d;
			rxcap_q <= rxcap_d;
		end
	end

	word_store u_txbuf (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.ce(ce),
		.wr_en(txbuf_we),
		.wr_idx(awaddr_q[BUF_AW+1:2]),
		.wr_data(merge(16'h0000, wdata_q, wstrb_q)),
		.rd_idx(tx_idx_q[BUF_AW-1:0]),
		.rd_data(tx_word)
	);

	// no clear port: old words stay until overwritten
	word_store u_rxbuf (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.ce(ce),
		.wr_en(rx_we),
		.wr_idx(rx_cnt_q[BUF_AW-1:0]),
		.wr_data(rx_wword),
		.rd_idx(s_axi_araddr[BUF_AW+1:2]),
		.rd_data(rx_rd)
	);

	ms_tick #(.CYCLES(MS_CYCLES_P)) u_tick (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.ce(ce),
		.restart(restart),
		.tick(tick)
	);

	// bytes pass through untouched, no checksum stage
	assign rx_byte = sel_two_q ? rx_data_two : rx_data_one;
	assign rx_fire = st_q == st_recv && (sel_two_q ? rx_valid_two : rx_valid_one);
	assign tx_fire = (txv_one_q && tx_ready_one) || (txv_two_q && tx_ready_two);
	assign mode_gap = rx_mode_word_q == MODE_GAP || rx_mode_word_q == MODE_START_GAP;
	assign port_busy = port_select_q == PORT_TWO ? claim_two_other : claim_one_other;

	always_comb begin
		bad = 1'b0;
		if (port_select_q != PORT_ONE && port_select_q != PORT_TWO) bad = 1'b1;
		if (rx_mode_word_q > MODE_COUNT) bad = 1'b1;
		if ($signed(tx_length_q) < 16'sd0 || $signed(tx_length_q) > MAX_TX_LEN) begin
			bad = 1'b1;
		end
		if (rx_mode_word_q == MODE_COUNT && (rxcap_q != param_q || txcap_q != tx_length_q)) begin
			bad = 1'b1;
		end
		if (rx_mode_word_q == MODE_GAP) begin
			gap_set = param_q > GAP_MAX ? GAP_MAX : (param_q < GAP_MIN ? GAP_MIN : param_q);
		end else begin
			gap_set = param_q[7:0] < GAP_MIN[7:0] ? GAP_MIN : {8'h00, param_q[7:0]};
		end
	end

	// engine: claim, send, receive
	always_comb begin
		st_d = st_q;
		done_d = done_q && !clr_done;
		timeout_d = timeout_q && !clr_tout;
		err_d = err_q && !clr_err;
		errcode_d = errcode_q;
		abort_d = abort_q;
		sel_two_d = sel_two_q;
		hi_d = hi_q;
		tx_idx_d = tx_idx_q;
		tx_byte_d = tx_byte_q;
		txv_one_d = txv_one_q;
		txv_two_d = txv_two_q;
		rx_cnt_d = rx_cnt_q;
		rx_hi_d = rx_hi_q;
		rx_hi_phase_d = rx_hi_phase_q;
		prev_d = prev_q;
		have_prev_d = have_prev_q;
		started_d = started_q;
		gap_d = gap_q;
		tmo_d = tmo_q;
		rx_we = 1'b0;
		rx_wword = {8'h00, rx_byte};
		store_ok = rx_cnt_q < rxcap_q[9:0] && rx_cnt_q < 10'(BUF_DEPTH);
		restart = rx_fire;
		ends = 1'b0;
		case (st_q)
			st_idle: begin
				// done or timeout held blocks restart, so characters are dropped here
				if (en && !done_q && !timeout_q) begin
					if (bad) begin
						err_d = 1'b1;
						errcode_d = ERR_PARAM;
					end else if (!port_busy) begin
						st_d = st_send;
						sel_two_d = port_select_q == PORT_TWO;
						abort_d = 1'b0;
						tx_idx_d = 10'h000;
						hi_d = !eight;
					end
				end
			end
			st_send: begin
				if (!en) abort_d = 1'b1;
				if (tx_fire) begin
					txv_one_d = 1'b0;
					txv_two_d = 1'b0;
					if (eight || !hi_q) begin
						tx_idx_d = tx_idx_q + 10'h001;
						hi_d = !eight;
					end else begin
						hi_d = 1'b0;
					end
				end else if (!txv_one_q && !txv_two_q) begin
					if ({6'h00, tx_idx_q} < tx_length_q) begin
						tx_byte_d = hi_q ? tx_word[15:8] : tx_word[7:0];
						txv_one_d = !sel_two_q;
						txv_two_d = sel_two_q;
					end else if (rx_mode_word_q == REG_RST) begin
						st_d = st_idle;
						done_d = !abort_q && en;
					end else if (abort_q || !en) begin
						st_d = st_idle;
					end else begin
						st_d = st_recv;
						restart = 1'b1;
						rx_cnt_d = 10'h000;
						rx_hi_phase_d = 1'b0;
						have_prev_d = 1'b0;
						started_d = 1'b0;
						gap_d = REG_RST;
						tmo_d = REG_RST;
					end
				end
			end
			st_recv: begin
				if (!en) begin
					st_d = st_idle;
				end else if (rx_fire) begin
					gap_d = REG_RST;
					if (!mode_gap) tmo_d = REG_RST;
					if (!started_q && (rx_mode_word_q == MODE_START_GAP ||
						rx_mode_word_q == MODE_START_END) && rx_byte != param_q[15:8]) begin
						started_d = 1'b0;
					end else begin
						started_d = 1'b1;
						if (eight) begin
							rx_we = store_ok;
						end else if (!rx_hi_phase_q) begin
							rx_hi_d = rx_byte;
							rx_hi_phase_d = 1'b1;
						end else begin
							rx_wword = {rx_hi_q, rx_byte};
							rx_hi_phase_d = 1'b0;
							rx_we = store_ok;
						end
						if (rx_we) rx_cnt_d = rx_cnt_q + 10'h001;
						prev_d = rx_byte;
						have_prev_d = 1'b1;
						case (rx_mode_word_q)
							MODE_END1: ends = rx_byte == param_q[7:0];
							MODE_END2: ends = have_prev_q && prev_q == param_q[15:8] &&
								rx_byte == param_q[7:0];
							MODE_START_END: ends = started_q && rx_byte == param_q[7:0];
							MODE_COUNT: ends = rx_cnt_d == param_q[9:0];
							default: ends = 1'b0;
						endcase
						if (ends) begin
							st_d = st_idle;
							done_d = 1'b1;
						end
					end
				end else if (tick) begin
					if (started_q && mode_gap) begin
						if (gap_q > gap_set) begin
							st_d = st_idle;
							done_d = 1'b1;
						end else if (gap_q != 16'hffff) begin
							gap_d = gap_q + 16'h0001;
						end
					end
					// in gap modes the count runs from the start of reception
					if (tperiod_q != REG_RST && st_d == st_recv) begin
						if (tmo_q > tperiod_q) begin
							st_d = st_idle;
							timeout_d = 1'b1;
						end else if (tmo_q != 16'hffff) begin
							tmo_d = tmo_q + 16'h0001;
						end
					end
				end
			end
			default: st_d = st_idle;
		endcase
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			st_q <= st_idle;
			done_q <= 1'b0;
			timeout_q <= 1'b0;
			err_q <= 1'b0;
			errcode_q <= REG_RST;
			abort_q <= 1'b0;
			sel_two_q <= 1'b0;
			hi_q <= 1'b0;
			tx_idx_q <= 10'h000;
			tx_byte_q <= 8'h00;
			txv_one_q <= 1'b0;
			txv_two_q <= 1'b0;
			rx_cnt_q <= 10'h000;
			rx_hi_q <= 8'h00;
			rx_hi_phase_q <= 1'b0;
			prev_q <= 8'h00;
			have_prev_q <= 1'b0;
			started_q <= 1'b0;
			gap_q <= REG_RST;
			tmo_q <= REG_RST;
			claim_one_q <= 1'b0;
			claim_two_q <= 1'b0;
		end else if (ce) begin
			st_q <= st_d;
			done_q <= done_d;
			timeout_q <= timeout_d;
			err_q <= err_d;
			errcode_q <= errcode_d;
			abort_q <= abort_d;
			sel_two_q <= sel_two_d;
			hi_q <= hi_d;
			tx_idx_q <= tx_idx_d;
			tx_byte_q <= tx_byte_d;
			txv_one_q <= txv_one_d;
			txv_two_q <= txv_two_d;
			rx_cnt_q <= rx_cnt_d;
			rx_hi_q <= rx_hi_d;
			rx_hi_phase_q <= rx_hi_phase_d;
			prev_q <= prev_d;
			have_prev_q <= have_prev_d;
			started_q <= started_d;
			gap_q <= gap_d;
			tmo_q <= tmo_d;
			claim_one_q <= st_d != st_idle && !sel_two_d;
			claim_two_q <= st_d != st_idle && sel_two_d;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign tx_data_one = tx_byte_q;
	assign tx_data_two = tx_byte_q;
	assign tx_valid_one = txv_one_q;
	assign tx_valid_two = txv_two_q;
	assign port_one_claimed = claim_one_q;
	assign port_two_claimed = claim_two_q;
	assign error_flag = err_q;
endmodule

// ---- hdl/serial_frame_pkg.sv ----
// shared constants and types for the serial frame engine
package serial_frame_pkg;
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_PORT = 12'h004;
	localparam logic [11:0] OFS_TXLEN = 12'h008;
	localparam logic [11:0] OFS_MODE = 12'h00c;
	localparam logic [11:0] OFS_PARAM = 12'h010;
	localparam logic [11:0] OFS_TOUT = 12'h014;
	localparam logic [11:0] OFS_TXCAP = 12'h018;
	localparam logic [11:0] OFS_RXCAP = 12'h01c;
	localparam logic [11:0] OFS_STAT = 12'h020;
	localparam logic [11:0] OFS_ERR = 12'h024;
	localparam logic [3:0] WIN_TXBUF = 4'h1;
	localparam logic [3:0] WIN_RXBUF = 4'h2;
	localparam int CTRL_EN = 0;
	localparam int CTRL_8BIT = 1;
	localparam int ST_DONE = 0;
	localparam int ST_TOUT = 1;
	localparam int ST_ERR = 2;
	localparam int ST_RXING = 3;
	localparam int ST_BUSY = 4;
	localparam int BUF_AW = 6;
	localparam int BUF_DEPTH = 64;
	localparam logic [15:0] REG_RST = 16'h0000;
	localparam logic [15:0] ERR_PARAM = 16'h2003;
	localparam logic signed [15:0] MAX_TX_LEN = 16'sd1000;
	localparam logic [15:0] GAP_MIN = 16'd2;
	localparam logic [15:0] GAP_MAX = 16'd3000;
	localparam logic [15:0] PORT_ONE = 16'd1;
	localparam logic [15:0] PORT_TWO = 16'd2;
	localparam logic [15:0] MODE_GAP = 16'd1;
	localparam logic [15:0] MODE_END1 = 16'd2;
	localparam logic [15:0] MODE_END2 = 16'd3;
	localparam logic [15:0] MODE_START_GAP = 16'd4;
	localparam logic [15:0] MODE_START_END = 16'd5;
	localparam logic [15:0] MODE_COUNT = 16'd6;
	localparam int CLK_PERIOD_NS = 4;
	localparam int MS_NS = 1000000;
	localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [1:0] {st_idle, st_send, st_recv} engine_state_e;
endpackage

// ---- hdl/ms_tick.sv ----
// millisecond tick generator with phase restart
`timescale 1ns/10ps
module ms_tick #(
	parameter int CYCLES = 250000
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic restart,
	output logic tick
);
	logic [31:0] cnt_q, cnt_d;
	logic tick_q, tick_d;

	// restart aligns the tick to the last character, so gaps are not short by a period
	always_comb begin
		cnt_d = cnt_q;
		tick_d = 1'b0;
		if (restart) begin
			cnt_d = 32'h0000_0000;
		end else if (cnt_q >= 32'(CYCLES - 1)) begin
			cnt_d = 32'h0000_0000;
			tick_d = 1'b1;
		end else begin
			cnt_d = cnt_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= 32'h0000_0000;
			tick_q <= 1'b0;
		end else if (ce) begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;
endmodule

// ---- hdl/word_store.sv ----
// flip-flop word buffer, one write port and one read port
`timescale 1ns/10ps
module word_store import serial_frame_pkg::*; (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic wr_en,
	input wire logic [BUF_AW-1:0] wr_idx,
	input wire logic [15:0] wr_data,
	input wire logic [BUF_AW-1:0] rd_idx,
	output logic [15:0] rd_data
);
	logic [15:0] mem_q [BUF_DEPTH];

	genvar i;
	generate
		for (i = 0; i < BUF_DEPTH; i++) begin : g_word
			always_ff @(posedge ref_clk or negedge resetn) begin
				if (!resetn) begin
					mem_q[i] <= REG_RST;
				end else if (ce && wr_en && wr_idx == BUF_AW'(i)) begin
					mem_q[i] <= wr_data;
				end
			end
		end
	endgenerate

	assign rd_data = mem_q[rd_idx];
endmodule

// ---- sim/serial_frame_checker.sv ----
// port assertions for the serial frame engine
`timescale 1ns/10ps
module serial_frame_checker (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [7:0] tx_data_one,
	input wire logic tx_valid_one,
	input wire logic tx_ready_one,
	input wire logic tx_valid_two,
	input wire logic claim_one_other,
	input wire logic port_one_claimed,
	input wire logic port_two_claimed,
	input wire logic error_flag
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	sequence byte_offered;
		tx_valid_one && !tx_ready_one;
	endsequence
	sequence byte_taken;
		tx_valid_one && tx_ready_one;
	endsequence
	a_tx_steady: assert property (byte_offered |=> tx_valid_one && $stable(tx_data_one))
		else $error("tx byte changed before accept");
	a_tx_spacing: assert property (byte_taken |=> !tx_valid_one)
		else $error("no idle cycle after tx byte");
	a_tx_owned: assert property (tx_valid_one |-> port_one_claimed)
		else $error("port one sends unclaimed");
	a_two_owned: assert property (tx_valid_two |-> port_two_claimed)
		else $error("port two sends unclaimed");
	a_claim_refused: assert property (claim_one_other && !port_one_claimed |=>
		!port_one_claimed) else $error("claimed a taken port");
	a_one_port: assert property (!(port_one_claimed && port_two_claimed))
		else $error("both ports claimed");
	a_err_idle: assert property ($rose(error_flag) |-> !port_one_claimed && !port_two_claimed)
		else $error("error raised while running");
	a_send_kept: assert property (tx_valid_one |=> port_one_claimed)
		else $error("send abandoned");
endmodule
bind serial_frame_send_receive serial_frame_checker chk_u (.ref_clk, .resetn, .tx_data_one,
	.tx_valid_one, .tx_ready_one, .tx_valid_two, .claim_one_other, .port_one_claimed,
	.port_two_claimed, .error_flag);

// ---- sim/serial_peer_model.sv ----
// behavioural serial equipment on one port
`timescale 1ns/10ps
module serial_peer_model (
	input wire logic ref_clk,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic [7:0] rx_data,
	output logic rx_valid
);
	logic [7:0] got[$];
	int pace = 1;
	int cnt = 0;
	initial begin
		tx_ready = 1'h0;
		rx_data = 8'h5a;
		rx_valid = 1'h0;
	end
	// pace above 1 stalls ready to stretch a send
	always @(posedge ref_clk) begin
		if (tx_valid && tx_ready)
			got.push_back(tx_data);
		cnt <= cnt + 1;
		tx_ready <= (cnt % pace) == 0;
	end
	task automatic send(input logic [7:0] b);
		@(posedge ref_clk);
		rx_data <= b;
		rx_valid <= 1'h1;
		@(posedge ref_clk);
		rx_valid <= 1'h0;
		rx_data <= ~b; // idle line must not repeat the byte
	endtask
endmodule

// ---- sim/serial_frame_send_receive_test.sv ----
// self-checking bench for the serial frame engine
`timescale 1ns/10ps
module serial_frame_send_receive_test import serial_frame_pkg::*; ;
	logic ref_clk = 1'h0, resetn = 1'h0, ce = 1'h1;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_bvalid;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
	logic s_axi_arready, s_axi_rvalid, claim_one_other = 1'h0, claim_two_other = 1'h0;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [7:0] tx_data_one, tx_data_two, rx_data_one, rx_data_two;
	logic tx_valid_one, tx_valid_two, tx_ready_one, tx_ready_two, rx_valid_one, rx_valid_two;
	logic port_one_claimed, port_two_claimed, error_flag;
	int mismatches = 0, total_checks = 0;
	serial_frame_send_receive #(.MS_CYCLES_P(20)) dut_u (.ref_clk, .resetn, .ce, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_data_one, .tx_valid_one,
		.tx_ready_one, .rx_data_one, .rx_valid_one, .tx_data_two, .tx_valid_two, .tx_ready_two,
		.rx_data_two, .rx_valid_two, .claim_one_other, .claim_two_other, .port_one_claimed,
		.port_two_claimed, .error_flag);
	serial_peer_model peer_one (.ref_clk, .tx_data(tx_data_one), .tx_valid(tx_valid_one),
		.tx_ready(tx_ready_one), .rx_data(rx_data_one), .rx_valid(rx_valid_one));
	serial_peer_model peer_two (.ref_clk, .tx_data(tx_data_two), .tx_valid(tx_valid_two),
		.tx_ready(tx_ready_two), .rx_data(rx_data_two), .rx_valid(rx_valid_two));
	initial begin
		forever #2 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge ref_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
		chk(s_axi_bresp, er);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er = RESP_OKAY);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge ref_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
		d = s_axi_rdata;
		chk(s_axi_rresp, er);
	endtask
	// order: port, tx length, rx mode, mode parameter, timeout, tx size, rx size
	task automatic cfg(input logic [15:0] v[7], input logic [15:0] ctrl);
		for (int i = 0; i < 7; i++) wr(OFS_PORT + 12'(4 * i), {16'h0, v[i]});
		wr(OFS_CTRL, {16'h0, ctrl});
	endtask
	task automatic poll(input int b);
		logic [31:0] v;
		int n = 0;
		do begin
			rd(OFS_STAT, v);
			n++;
		end while (!v[b] && n < 300);
		chk(v[b], 1'h1);
	endtask
	task automatic await_bytes(input int n);
		repeat (600) if (peer_one.got.size() < n) @(posedge ref_clk);
		repeat (4) @(posedge ref_clk);
		chk(peer_one.got.size(), n);
	endtask
	task automatic stop();
		wr(OFS_CTRL, 32'h0);
		wr(OFS_STAT, 32'h7);
		repeat (4) @(posedge ref_clk);
		peer_one.got.delete();
	endtask
	task automatic t_bus();
		logic [31:0] v;
		rd(OFS_STAT, v);
		chk(v, 32'h0);
		rd(12'h030, v, RESP_SLVERR);
		wr(12'h200, 32'h1, RESP_SLVERR);
		rd(12'h100, v, RESP_SLVERR);
		wr(OFS_PARAM, 32'h1234);
		s_axi_wstrb <= 4'h2;
		wr(OFS_PARAM, 32'hab00);
		s_axi_wstrb <= 4'hf;
		rd(OFS_PARAM, v);
		chk(v, 32'hab34);
		$display("bus test done");
	endtask
	task automatic t_errors();
		logic [31:0] v;
		logic [15:0] bad[6][7] = '{'{16'h3, 16'h1, 16'h2, 16'ha, 16'h0, 16'h1, 16'h4},
			'{16'h1, 16'h1, 16'h7, 16'ha, 16'h0, 16'h1, 16'h4},
			'{16'h1, 16'h3e9, 16'h2, 16'ha, 16'h0, 16'h3e9, 16'h4},
			'{16'h1, 16'hffff, 16'h2, 16'ha, 16'h0, 16'h1, 16'h4},
			'{16'h1, 16'h1, 16'h6, 16'h2, 16'h0, 16'h1, 16'h3},
			'{16'h1, 16'h1, 16'h6, 16'h2, 16'h0, 16'h2, 16'h2}};
		foreach (bad[k]) begin
			cfg(bad[k], 16'h1);
			poll(ST_ERR);
			rd(OFS_ERR, v);
			chk(v, 32'h2003);
			chk(error_flag, 1'h1);
			chk(peer_one.got.size(), 0);
			stop();
		end
		$display("parameter error test done");
	endtask
	task automatic t_frame();
		logic [31:0] v;
		wr(12'h100, 32'hab41);
		wr(12'h104, 32'hcd0d);
		cfg('{16'h1, 16'h2, 16'h2, 16'ha, 16'h0, 16'h2, 16'h2}, 16'h3);
		await_bytes(2);
		chk(peer_one.got[0], 8'h41);
		chk(peer_one.got[1], 8'h0d);
		ce <= 1'h0;
		peer_one.send(8'h99); // frozen engine must miss this byte
		ce <= 1'h1;
		peer_one.send(8'h31);
		peer_one.send(8'h32);
		peer_one.send(8'h0a);
		poll(ST_DONE);
		peer_one.send(8'h55);
		rd(OFS_STAT, v);
		chk(v[25:16], 10'h2);
		rd(12'h200, v);
		chk(v, 32'h31);
		rd(12'h204, v);
		chk(v, 32'h32);
		peer_one.got.delete();
		wr(OFS_STAT, 32'h1);
		await_bytes(2);
		stop();
		$display("end character test done");
	endtask
	task automatic t_wide();
		logic [31:0] v;
		wr(12'h100, 32'h1234);
		cfg('{16'h1, 16'h1, 16'h6, 16'h2, 16'h0, 16'h1, 16'h2}, 16'h1);
		await_bytes(2);
		chk({peer_one.got[0], peer_one.got[1]}, 16'h1234);
		for (int i = 0; i < 4; i++) peer_one.send(8'ha1 + 8'(i * 17));
		poll(ST_DONE);
		rd(12'h200, v);
		chk(v, 32'ha1b2);
		rd(12'h204, v);
		chk(v, 32'hc3d4);
		stop();
		$display("wide count test done");
	endtask
	task automatic t_timeout();
		logic [31:0] v;
		wr(12'h100, 32'h77);
		cfg('{16'h1, 16'h1, 16'h2, 16'ha, 16'h3, 16'h1, 16'h4}, 16'h3);
		await_bytes(1);
		repeat (45) @(posedge ref_clk);
		peer_one.send(8'h10);
		repeat (60) @(posedge ref_clk);
		rd(OFS_STAT, v);
		chk(v[1:0], 2'h0);
		poll(ST_TOUT);
		peer_one.got.delete();
		wr(OFS_STAT, 32'h2);
		await_bytes(1);
		stop();
		$display("timeout test done");
	endtask
	task automatic t_gap();
		logic [31:0] v;
		cfg('{16'h1, 16'h1, 16'h1, 16'h1, 16'h0, 16'h1, 16'h4}, 16'h3);
		await_bytes(1);
		peer_one.send(8'h21);
		repeat (48) @(posedge ref_clk);
		peer_one.send(8'h22);
		repeat (70) @(posedge ref_clk);
		rd(OFS_STAT, v);
		chk(v[0], 1'h0);
		poll(ST_DONE);
		rd(12'h204, v);
		chk(v, 32'h22);
		stop();
		$display("gap test done");
	endtask
	task automatic t_hold();
		logic [31:0] v;
		peer_one.pace = 16;
		cfg('{16'h1, 16'h3, 16'h0, 16'h0, 16'h0, 16'h3, 16'h4}, 16'h3);
		await_bytes(1);
		wr(OFS_CTRL, 32'h0);
		await_bytes(3);
		rd(OFS_STAT, v);
		chk(v[0], 1'h0);
		peer_one.pace = 1;
		stop();
		$display("enable drop test done");
	endtask
	task automatic t_claim();
		logic [31:0] v;
		claim_one_other <= 1'h1;
		cfg('{16'h1, 16'h1, 16'h0, 16'h0, 16'h0, 16'h1, 16'h4}, 16'h3);
		repeat (40) @(posedge ref_clk);
		chk(port_one_claimed, 1'h0);
		chk(peer_one.got.size(), 0);
		wr(OFS_CTRL, 32'h0);
		claim_one_other <= 1'h0;
		claim_two_other <= 1'h1;
		wr(OFS_PORT, 32'h2);
		wr(OFS_MODE, 32'h2);
		wr(OFS_PARAM, 32'ha);
		wr(OFS_CTRL, 32'h3);
		repeat (40) @(posedge ref_clk);
		chk(port_two_claimed, 1'h0);
		claim_two_other <= 1'h0;
		repeat (40) @(posedge ref_clk);
		chk(peer_two.got.size(), 1);
		chk(peer_two.got[0], 8'h77);
		peer_two.send(8'h0a);
		poll(ST_DONE);
		rd(12'h200, v);
		chk(v, 32'h0a);
		stop();
		$display("claim test done");
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		mismatches++;
		complete_run();
	end
	initial begin
		repeat (6) @(posedge ref_clk);
		resetn <= 1'h1;
		repeat (2) @(posedge ref_clk);
		t_bus();
		t_errors();
		t_frame();
		t_wide();
		t_timeout();
		t_gap();
		t_hold();
		t_claim();
		complete_run();
	end
endmodule
